//--- src/qusi_host_port.sv
// Purpose: Host bus channel select, ready summary read and channel interrupts
// Assumes: All pin inputs synchronous to clock_i; channel registers live outside
// Notes:   Data bus is split into input, output and output enable
`include "qusi_regs.svh"

// Function
// [R1] Processor style: shared active-low select low makes all four channels eligible.
// [R2] Processor style: upper channel address picks the one responding channel.
// [R3] Per-channel style: each channel with its select low transfers data.
// [R4] Per-channel style: shared select input acts as channel A select.
// [R5] Ready select low drives inverted tx flags on bits 0-3, rx on 4-7.
// [R6] Eight-bit three-state data bus, bit 0 least significant.
// [R7] Channel interrupt driven when modem control bit 3, enable and pending; the code does so in per-channel style only.
// [R8] Bus style input high selects per-channel style, low processor style.
// [R9] Pending from receive errors, data, holding empty or modem change.
// [R10] Interrupt drive select high keeps interrupts driven regardless of bit 3; the code does so in per-channel style only.
// [R11] Data bus released unless ready select is low or a read with a valid select is active.
module qusi_host_port
    import qusi_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   resetn_i,
    input  wire logic                   enable_i,
    input  wire logic                   bus_style_i,
    input  wire logic                   first_channel_select_n_i,
    input  wire logic [1:0]             upper_channel_address_i,
    input  wire logic [3:1]             chan_select_n_i,
    input  wire logic                   read_n_i,
    input  wire logic                   write_n_i,
    input  wire logic                   ready_status_select_n_i,
    input  wire qusi_pkg::qusi_chan_vec_t   tx_space_flag_i,
    input  wire qusi_pkg::qusi_chan_vec_t   rx_data_flag_i,
    input  wire qusi_pkg::qusi_chan_bytes_t chan_read_data_i,
    input  wire qusi_pkg::qusi_chan_bytes_t modem_control_reg_i,
    input  wire qusi_pkg::qusi_chan_cond_t  irq_enable_reg_i,
    input  wire qusi_pkg::qusi_chan_cond_t  irq_cond_i,
    input  wire logic                   irq_drive_select_i,
    input  wire qusi_pkg::qusi_byte_t   data_i,
    output qusi_pkg::qusi_byte_t        data_o,
    output logic                        data_oe_o,
    output qusi_pkg::qusi_chan_vec_t    chan_access_o,
    output qusi_pkg::qusi_chan_vec_t    chan_read_o,
    output qusi_pkg::qusi_chan_vec_t    chan_write_o,
    output qusi_pkg::qusi_byte_t        chan_write_data_o,
    output qusi_pkg::qusi_chan_vec_t    irq_o,
    output qusi_pkg::qusi_chan_vec_t    irq_oe_o
);
    import qusi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    // Synchroniser keeps running while enable_i is low

    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Channel select decode

    qusi_style_t    style;
    qusi_chan_vec_t sel;
    qusi_byte_t     summary;

    always_comb
    begin
        style = (bus_style_i == `QUSI_STYLE_PERCHAN) ? qusi_style_perchan : qusi_style_proc; // [R8]
        sel   = `QUSI_CHAN_RESET;
        case (style)
            qusi_style_proc:
            begin
                if (!first_channel_select_n_i) // [R1]
                    sel[upper_channel_address_i] = 1'b1; // [R2]
            end
            qusi_style_perchan:
            begin
                sel = ~{chan_select_n_i, first_channel_select_n_i}; // [R3] [R4]
            end
            default:
            begin
                sel = `QUSI_CHAN_RESET;
            end
        endcase
        // Ready summary bits are active-low copies of the flags
        summary = `QUSI_BYTE_RESET;
        summary[`QUSI_RDY_TX_LSB +: `QUSI_NUM_CHAN] = ~tx_space_flag_i; // [R5]
        summary[`QUSI_RDY_RX_LSB +: `QUSI_NUM_CHAN] = ~rx_data_flag_i; // [R5]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data bus drive

    qusi_drv_t      drv;
    qusi_drv_t      next_drv;
    qusi_byte_t     next_data;
    qusi_byte_t     chan_mux;
    qusi_chan_vec_t next_access;
    qusi_chan_vec_t next_read;
    qusi_chan_vec_t next_write;
    qusi_byte_t     next_wdata;
    qusi_byte_t     data_q;
    qusi_chan_vec_t access_q;
    qusi_chan_vec_t read_q;
    qusi_chan_vec_t write_q;
    qusi_byte_t     wdata_q;

    always_comb
    begin
        // Several per-channel selects low on a read: the lowest channel drives
        chan_mux = `QUSI_BYTE_RESET;
        for (int c = `QUSI_NUM_CHAN - 1; c >= 0; c--)
        begin
            if (sel[c])
                chan_mux = chan_read_data_i[c*`QUSI_DATA_W +: `QUSI_DATA_W]; // [R6]
        end
        next_access = sel;
        next_read   = read_n_i ? `QUSI_CHAN_RESET : sel;
        next_write  = write_n_i ? `QUSI_CHAN_RESET : sel; // [R3]
        next_wdata  = data_i; // [R6]
        next_data   = data_q;
        // Ready summary has priority over a channel read
        if (!ready_status_select_n_i)
            next_drv = qusi_drv_summary; // [R5]
        else if (!read_n_i && (|sel))
            next_drv = qusi_drv_chan;
        else
            next_drv = qusi_drv_idle; // [R11]
        case (next_drv)
            qusi_drv_summary:
            begin
                next_data = summary; // [R5]
            end
            qusi_drv_chan:
            begin
                next_data = chan_mux;
            end
            default:
            begin
                next_data = data_q;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv      <= qusi_drv_idle;
            data_q   <= `QUSI_BYTE_RESET;
            access_q <= `QUSI_CHAN_RESET;
            read_q   <= `QUSI_CHAN_RESET;
            write_q  <= `QUSI_CHAN_RESET;
            wdata_q  <= `QUSI_BYTE_RESET;
        end
        else if (enable_i)
        begin
            drv      <= next_drv;
            data_q   <= next_data;
            access_q <= next_access;
            read_q   <= next_read;
            write_q  <= next_write;
            wdata_q  <= next_wdata;
        end
    end

    // data_o keeps its last byte while the bus is released
    assign data_o            = data_q;
    assign data_oe_o         = (drv != qusi_drv_idle); // [R11]
    assign chan_access_o     = access_q;
    assign chan_read_o       = read_q;
    assign chan_write_o      = write_q;
    assign chan_write_data_o = wdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Channel interrupts
    // Processor style leaves every interrupt pin undriven; any wire-OR sits outside

    qusi_chan_vec_t next_irq;
    qusi_chan_vec_t next_irq_oe;
    qusi_chan_vec_t irq_q;
    qusi_chan_vec_t irq_oe_q;

    for (genvar g = 0; g < `QUSI_NUM_CHAN; g++)
    begin : g_chan
        qusi_irq_chan u_irq
        (
            .perchan_i          (style == qusi_style_perchan), // [R7]
            .irq_drive_select_i (irq_drive_select_i), // [R10]
            .modem_ctrl_irq_oe_i (modem_control_reg_i[g*`QUSI_DATA_W + `QUSI_MODEM_CTRL_IRQ_OE_BIT]), // [R7]
            .cond_i             (irq_cond_i[g*`QUSI_NUM_COND +: `QUSI_NUM_COND]), // [R9]
            .irq_enable_reg_i   (irq_enable_reg_i[g*`QUSI_NUM_COND +: `QUSI_NUM_COND]),
            .irq_o              (next_irq[g]),
            .irq_oe_o           (next_irq_oe[g])
        );
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q    <= `QUSI_CHAN_RESET;
            irq_oe_q <= `QUSI_CHAN_RESET;
        end
        else if (enable_i)
        begin
            irq_q    <= next_irq;
            irq_oe_q <= next_irq_oe;
        end
    end

    assign irq_o    = irq_q;
    assign irq_oe_o = irq_oe_q;
endmodule // qusi_host_port

//--- src/qusi_irq_chan.sv
// Purpose: Interrupt level and drive enable of one channel
// Assumes: Inputs synchronous to the port clock
// Notes:   Combinational; the parent registers the results
`include "qusi_regs.svh"

module qusi_irq_chan
    import qusi_pkg::*;
(
    input  wire logic                      perchan_i,
    input  wire logic                      irq_drive_select_i,
    input  wire logic                      modem_ctrl_irq_oe_i,
    input  wire logic [`QUSI_NUM_COND-1:0] cond_i,
    input  wire logic [`QUSI_NUM_COND-1:0] irq_enable_reg_i,
    output logic                           irq_o,
    output logic                           irq_oe_o
);
    import qusi_pkg::*;

    logic pending;

    always_comb
    begin
        // Errors, data available, holding empty, modem change, each gated by its enable
        pending  = |(cond_i & irq_enable_reg_i); // [R9]
        irq_oe_o = perchan_i && (irq_drive_select_i || modem_ctrl_irq_oe_i); // [R7] [R10]
        irq_o    = irq_oe_o && pending; // [R7]
    end
endmodule // qusi_irq_chan

//--- src/qusi_pkg.sv
// Purpose: Types for the quad UART host select and interrupt port
// Assumes: qusi_regs.svh holds every number
// Notes:   Types only
`include "qusi_regs.svh"

package qusi_pkg;
    typedef logic [`QUSI_DATA_W-1:0]                   qusi_byte_t;
    typedef logic [`QUSI_NUM_CHAN-1:0]                 qusi_chan_vec_t;
    typedef logic [`QUSI_NUM_CHAN*`QUSI_DATA_W-1:0]    qusi_chan_bytes_t;
    typedef logic [`QUSI_NUM_CHAN*`QUSI_NUM_COND-1:0]  qusi_chan_cond_t;
    typedef enum logic { qusi_style_proc, qusi_style_perchan } qusi_style_t;
    typedef enum logic [1:0] { qusi_drv_idle, qusi_drv_summary, qusi_drv_chan } qusi_drv_t;
endpackage

//--- src/qusi_regs.svh
// Purpose: Constants for the quad UART host select and interrupt port
// Assumes: Included by bare name from the package and the modules
// Notes:   Definitions only
`ifndef QUSI_REGS_SVH
`define QUSI_REGS_SVH

`define QUSI_NUM_CHAN        4
`define QUSI_DATA_W          8
`define QUSI_NUM_COND        4
`define QUSI_RDY_TX_LSB      0
`define QUSI_RDY_RX_LSB      4
`define QUSI_MODEM_CTRL_IRQ_OE_BIT 3
`define QUSI_STYLE_PERCHAN   1'b1
`define QUSI_BYTE_RESET      8'h00
`define QUSI_CHAN_RESET      4'h0

`endif

//--- verif/qusi_host_model.sv
// Purpose: Host processor driving the select and strobe pins
// Assumes: Bench calls put once per bus cycle
// Notes:   Released data bus shows the inverted last value
module qusi_host_model
    import qusi_pkg::*;
(
    input  wire logic            clock_i,
    output logic                 style_o,
    output logic                 shared_sel_n_o,
    output logic                 rd_n_o,
    output logic                 wr_n_o,
    output logic                 rdy_n_o,
    output logic [1:0]           addr_o,
    output logic [3:1]           cs_n_o,
    output qusi_pkg::qusi_byte_t d_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {style_o, shared_sel_n_o, rd_n_o, wr_n_o, rdy_n_o, addr_o, cs_n_o, d_o} = {5'h0f, 2'h0, 3'h7, 8'h00};
    task put(input logic s, c, input logic [1:0] a, input logic [3:1] cs, input logic r, w, y, input qusi_byte_t d);
        @(posedge clock_i);
        style_o <= s;
        shared_sel_n_o <= c;
        addr_o <= a;
        cs_n_o <= cs;
        rd_n_o <= r;
        wr_n_o <= w;
        rdy_n_o <= y;
        d_o <= w ? ~d_o : d;
    endtask
endmodule // qusi_host_model

//--- verif/qusi_host_port_checker.sv
// Purpose: Port-level checks of the host select and interrupt port
// Assumes: Checks other than AST_FREEZE pause while enable_i is low
// Notes:   Bound to qusi_host_port
module qusi_host_port_checker
    import qusi_pkg::*;
(
    input wire logic                       clock_i,
    input wire logic                       resetn_i,
    input wire logic                       enable_i,
    input wire logic                       bus_style_i,
    input wire logic                       first_channel_select_n_i,
    input wire logic [1:0]                 upper_channel_address_i,
    input wire logic [3:1]                 chan_select_n_i,
    input wire logic                       read_n_i,
    input wire logic                       write_n_i,
    input wire logic                       ready_status_select_n_i,
    input wire qusi_pkg::qusi_chan_vec_t   tx_space_flag_i,
    input wire qusi_pkg::qusi_chan_vec_t   rx_data_flag_i,
    input wire qusi_pkg::qusi_chan_bytes_t modem_control_reg_i,
    input wire qusi_pkg::qusi_chan_cond_t  irq_enable_reg_i,
    input wire qusi_pkg::qusi_chan_cond_t  irq_cond_i,
    input wire logic                       irq_drive_select_i,
    input wire qusi_pkg::qusi_byte_t       data_i,
    input wire qusi_pkg::qusi_byte_t       data_o,
    input wire logic                       data_oe_o,
    input wire qusi_pkg::qusi_chan_vec_t   chan_access_o,
    input wire qusi_pkg::qusi_chan_vec_t   chan_read_o,
    input wire qusi_pkg::qusi_chan_vec_t   chan_write_o,
    input wire qusi_pkg::qusi_byte_t       chan_write_data_o,
    input wire qusi_pkg::qusi_chan_vec_t   irq_o,
    input wire qusi_pkg::qusi_chan_vec_t   irq_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] rdy;
    logic [3:0] pend, oe_exp;
    wire live = rdy[2] & enable_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Skips the cycles while the internal reset copy is still held
    always_ff @(posedge clock_i or negedge resetn_i)
        if (!resetn_i) rdy <= 3'h0;
        else rdy <= {rdy[1:0], 1'b1};
    always_ff @(posedge clock_i)
        for (int n = 0; n < 4; n++)
        begin
            pend[n] <= |(irq_cond_i[4*n+:4] & irq_enable_reg_i[4*n+:4]);
            oe_exp[n] <= bus_style_i & (irq_drive_select_i | modem_control_reg_i[8*n+3]);
        end
    AST_SUMMARY: assert property (live && !ready_status_select_n_i |=> data_oe_o
        && data_o == {~$past(rx_data_flag_i), ~$past(tx_space_flag_i)}) else $error("summary byte wrong");
    AST_PROC_SEL: assert property (live && !bus_style_i && !first_channel_select_n_i
        |=> chan_access_o == 4'h1 << $past(upper_channel_address_i)) else $error("proc select wrong");
    AST_PROC_DESEL: assert property (live && !bus_style_i && first_channel_select_n_i
        |=> chan_access_o == 4'h0) else $error("proc access without select");
    AST_PERCHAN_SEL: assert property (live && bus_style_i |=> chan_access_o
        == ~$past({chan_select_n_i, first_channel_select_n_i})) else $error("per-channel select wrong");
    AST_CHAN_READ: assert property (live |=> chan_read_o
        == (chan_access_o & {4{!$past(read_n_i)}})) else $error("channel read wrong");
    AST_WRITE: assert property (live && !write_n_i |=> chan_write_data_o == $past(data_i)
        && chan_write_o == chan_access_o) else $error("channel write wrong");
    AST_RELEASE: assert property (live && read_n_i && ready_status_select_n_i
        |=> !data_oe_o) else $error("bus driven without read");
    AST_IRQ_OE: assert property (live |=> irq_oe_o == oe_exp) else $error("irq drive wrong");
    AST_IRQ: assert property (live |=> irq_o == (irq_oe_o & pend)) else $error("irq level wrong");
    AST_FREEZE: assert property (rdy[2] && !enable_i |=> $stable(chan_access_o) && $stable(data_oe_o)
        && $stable(data_o) && $stable(irq_o) && $stable(irq_oe_o)) else $error("state moved while frozen");
    cover property (live && !ready_status_select_n_i);
    cover property (live && !bus_style_i && !first_channel_select_n_i && !read_n_i);
    cover property (live && |irq_o);
endmodule // qusi_host_port_checker

bind qusi_host_port qusi_host_port_checker u_qusi_host_port_checker (.*);

//--- verif/tb_qusi_host_port.sv
// Purpose: Self-checking bench of the host select and interrupt port
// Assumes: Channel registers fixed, flags and drive select driven
// Notes:   One bus cycle per op call
module tb_qusi_host_port
    import qusi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, resetn_i = 1'b0, isel = 1'b0, en = 1'b1, st, shared_sel_n, rd_n, wr_n, rdy_n, doe;
    logic [1:0] addr;
    logic [3:1] cs_n;
    qusi_byte_t d, dout, wdat;
    qusi_chan_vec_t tx = 4'h0, rx = 4'h0, acc, crd, cwr, irq, irq_oe;
    int n_mismatch = 0, n_checks = 0;
    always #2 clock_i = ~clock_i;
    qusi_host_model u_qusi_host_model (.clock_i(clock_i), .style_o(st), .shared_sel_n_o(shared_sel_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .rdy_n_o(rdy_n), .addr_o(addr), .cs_n_o(cs_n), .d_o(d));
    qusi_host_port u_qusi_host_port (.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(en),
        .bus_style_i(st), .first_channel_select_n_i(shared_sel_n), .upper_channel_address_i(addr),
        .chan_select_n_i(cs_n), .read_n_i(rd_n), .write_n_i(wr_n), .ready_status_select_n_i(rdy_n),
        .tx_space_flag_i(tx), .rx_data_flag_i(rx), .chan_read_data_i(32'h44332211),
        .modem_control_reg_i(32'h00000008), .irq_enable_reg_i(16'h0101), .irq_cond_i(16'h0111),
        .irq_drive_select_i(isel), .data_i(d), .data_o(dout), .data_oe_o(doe), .chan_access_o(acc),
        .chan_read_o(crd), .chan_write_o(cwr), .chan_write_data_o(wdat), .irq_o(irq), .irq_oe_o(irq_oe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic s, c, input logic [1:0] a, input logic [3:1] cs, input logic r, w, y,
        input qusi_byte_t dd);
        u_qusi_host_model.put(s, c, a, cs, r, w, y, dd);
        @(posedge clock_i);
        #1;
    endtask
    task automatic results;
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_proc;
        for (int i = 0; i < 4; i++)
        begin
            op(1'b0, 1'b0, i[1:0], 3'h7, 1'b0, 1'b1, 1'b1, 8'h00);
            chk(acc, 4'h1 << i);
            chk(crd, 4'h1 << i);
            chk(doe, 1'b1);
            chk(dout, 8'h11 * (i + 1));
        end
        op(1'b0, 1'b1, 2'h1, 3'h0, 1'b0, 1'b1, 1'b1, 8'h00);
        chk({acc, doe}, 5'h00);
    endtask
    task automatic t_perchan;
        op(1'b1, 1'b1, 2'h0, 3'h2, 1'b1, 1'b0, 1'b1, 8'h5a);
        chk(cwr, 4'ha);
        chk(wdat, 8'h5a);
        chk(doe, 1'b0);
        op(1'b1, 1'b0, 2'h3, 3'h7, 1'b0, 1'b1, 1'b1, 8'h00);
        chk(acc, 4'h1);
        chk(dout, 8'h11);
        op(1'b1, 1'b1, 2'h0, 3'h2, 1'b0, 1'b1, 1'b1, 8'h00);
        chk(crd, 4'ha);
        chk(dout, 8'h22);
    endtask
    task automatic t_summary;
        @(posedge clock_i);
        tx <= 4'h5;
        rx <= 4'h3;
        op(1'b0, 1'b0, 2'h2, 3'h7, 1'b0, 1'b1, 1'b0, 8'h00);
        chk({doe, dout}, 9'h1ca);
        op(1'b0, 1'b1, 2'h0, 3'h7, 1'b1, 1'b1, 1'b1, 8'h00);
        chk(doe, 1'b0);
    endtask
    task automatic t_freeze;
        @(posedge clock_i);
        en <= 1'b0;
        op(1'b0, 1'b0, 2'h3, 3'h7, 1'b0, 1'b1, 1'b1, 8'h00);
        chk({doe, acc}, 5'h00);          // frozen
        @(posedge clock_i);
        en <= 1'b1;
        op(1'b0, 1'b0, 2'h3, 3'h7, 1'b0, 1'b1, 1'b1, 8'h00);
        chk({doe, acc, dout}, 13'h1844);
    endtask
    task automatic t_irq;
        op(1'b1, 1'b1, 2'h0, 3'h7, 1'b1, 1'b1, 1'b1, 8'h00);
        chk({irq_oe, irq}, 8'h11);
        @(posedge clock_i);
        isel <= 1'b1;
        op(1'b1, 1'b1, 2'h0, 3'h7, 1'b1, 1'b1, 1'b1, 8'h00);
        chk({irq_oe, irq}, 8'hf5);
        op(1'b0, 1'b1, 2'h0, 3'h7, 1'b1, 1'b1, 1'b1, 8'h00);
        chk({irq_oe, irq}, 8'h00);
    endtask
    task automatic t_reset;
        op(1'b0, 1'b0, 2'h1, 3'h7, 1'b0, 1'b1, 1'b0, 8'h00);
        chk({doe, acc}, 5'h12);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        #1;
        chk({doe, acc, crd}, 9'h000);
        @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk({doe, acc, crd}, 9'h000);
        @(posedge clock_i);
        #1;
        chk({doe, acc, dout}, 13'h12ca);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_proc;
        t_perchan;
        t_summary;
        t_freeze;
        t_irq;
        t_reset;
        results;
    end
    initial
    begin
        #2000;
        n_mismatch++;
        results;
    end
endmodule // tb_qusi_host_port
